// File: design/ifb_irq_bank.sv
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
// Functional notes
// - Group flags sit in bits 7..4
// - Group enables sit in bits 3..0
// - Frame-start flag bit 7, enable bit 3
// - USB flag bit 6, enable bit 2
// - Tick1/tick0 flags bits 5,4; enables 1,0
// - Serial module flag bit 6, enable bit 2
// - Async port1 flag bit 5, enable bit 1
// - Async port0 flag bit 4, enable bit 0
// - Serial bits 7,3 read zero, ignore writes
// - Group flag collects its per-source requests
module ifb_irq_bank import ifb_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [GRP_N-1:0] group_src_req,
  input wire logic [UTB_N-1:0] usb_tick_req,
  input wire logic [SER_N-1:0] serial_req,
  output logic [EV_W-1:0] core_req_q,
  output logic global_irq_en,
  output logic irq
);
  ifb_reg_if rb ();
  logic [GRP_N-1:0] grp_flag;
  logic [GRP_N-1:0] grp_en;
  logic [UTB_N-1:0] utb_flag;
  logic [UTB_N-1:0] utb_en;
  logic [SER_N-1:0] ser_flag;
  logic [SER_N-1:0] ser_en;
  logic gie_q;
  logic [EV_W-1:0] ev_stat_q;
  logic [EV_W-1:0] ev_mask_q;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] flags;
  logic [EV_W-1:0] enables;
  logic lane0;
  logic lane1;
  logic we_mf;
  logic we_utb;
  logic we_ser;
  logic we_ctrl;
  logic we_stat;
  logic we_mask;
  logic [REG_W-1:0] ser_byte;
  logic [7:0] wb0;
  logic [EV_W-1:0] wev;

  ifb_avs u_avs (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .rb(rb.bus)
  );

  assign lane0 = rb.wmask[0];
  assign lane1 = rb.wmask[8];
  assign wb0 = rb.wdata[7:0];
  assign wev = rb.wdata[EV_W-1:0] & rb.wmask[EV_W-1:0];
  assign we_mf = rb.wr && lane0 && (rb.addr == OFF_MF);
  assign we_utb = rb.wr && lane0 && (rb.addr == OFF_UTB);
  assign we_ser = rb.wr && lane0 && (rb.addr == OFF_SER);
  assign we_ctrl = rb.wr && lane0 && (rb.addr == OFF_CTRL);
  assign we_stat = rb.wr && (lane0 || lane1) && (rb.addr == OFF_EV_STAT);
  assign we_mask = rb.wr && (lane0 || lane1) && (rb.addr == OFF_EV_MASK);

  // Group request inputs are the already-combined per-source requests
  ifb_flag_bank #(.N(GRP_N)) u_mf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .hw_set(group_src_req),
    .sw_we(we_mf),
    .sw_flag(wb0[FLAG_LSB +: GRP_N]),
    .sw_en(wb0[EN_LSB +: GRP_N]),
    .flag_q(grp_flag),
    .en_q(grp_en)
  );

  ifb_flag_bank #(.N(UTB_N)) u_utb (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .hw_set(usb_tick_req),
    .sw_we(we_utb),
    .sw_flag(wb0[FLAG_LSB +: UTB_N]),
    .sw_en(wb0[EN_LSB +: UTB_N]),
    .flag_q(utb_flag),
    .en_q(utb_en)
  );

  // Reserved bits 7 and 3 are simply not stored
  ifb_flag_bank #(.N(SER_N)) u_ser (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .hw_set(serial_req),
    .sw_we(we_ser),
    .sw_flag(wb0[FLAG_LSB +: SER_N]),
    .sw_en(wb0[EN_LSB +: SER_N]),
    .flag_q(ser_flag),
    .en_q(ser_en)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gie_q <= RST_CTRL_BYTE[CTRL_GIE];
    end else if (we_ctrl) begin
      gie_q <= wb0[CTRL_GIE];
    end
  end
  assign global_irq_en = gie_q;

  assign ev = {serial_req, usb_tick_req, group_src_req};
  assign flags = {ser_flag, utb_flag, grp_flag};
  assign enables = {ser_en, utb_en, grp_en};

  // Flags stay set until software clears them; nothing here clears on entry
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      core_req_q <= RST_EV;
    end else begin
      core_req_q <= gie_q ? (flags & enables) : RST_EV;
    end
  end

  // Event status: set wins over write-one-to-clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ev_stat_q <= RST_EV;
    end else begin
      ev_stat_q <= ev | (ev_stat_q & ~(we_stat ? wev : RST_EV));
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ev_mask_q <= RST_EV;
    end else if (we_mask) begin
      ev_mask_q <= (ev_mask_q & ~rb.wmask[EV_W-1:0]) | wev;
    end
  end
  assign irq = |(ev_stat_q & ev_mask_q);

  assign ser_byte = {1'b0, ser_flag, 1'b0, ser_en};

  always_comb begin
    rb.rdata = '0;
    unique case (rb.addr)
      OFF_MF: rb.rdata[REG_W-1:0] = {grp_flag, grp_en};
      OFF_UTB: rb.rdata[REG_W-1:0] = {utb_flag, utb_en};
      OFF_SER: rb.rdata[REG_W-1:0] = ser_byte;
      OFF_CTRL: rb.rdata[CTRL_GIE] = gie_q;
      OFF_EV_STAT: rb.rdata[EV_W-1:0] = ev_stat_q;
      OFF_EV_MASK: rb.rdata[EV_W-1:0] = ev_mask_q;
      default: rb.rdata = '0;
    endcase
  end

  AST_GRP_FLAG_SET: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    group_src_req[GRP_N-1] |=> grp_flag[GRP_N-1] [*1]
  ) else $error("group 3 flag not set by its request");

  AST_GRP_EN_WRITE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    we_mf |=> grp_en == $past(rb.wdata[EN_LSB +: GRP_N])
  ) else $error("group enables not loaded from write");

  AST_SOF_LAYOUT: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (avs_read && !avs_waitrequest && avs_address == OFF_UTB)
    |-> avs_readdata[7] == $past(utb_flag[UTB_SOF])
      && avs_readdata[3] == $past(utb_en[UTB_SOF])
  ) else $error("frame start bits misplaced");

  AST_USB_FWD: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (utb_flag[UTB_USB] && utb_en[UTB_USB] && gie_q) |=> core_req_q[EV_UTB_LSB + UTB_USB]
  ) else $error("usb request not forwarded");

  AST_TICK_HOLD: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (usb_tick_req[UTB_TICK1] ##1 !we_utb [*2]) |-> utb_flag[UTB_TICK1]
  ) else $error("tick1 flag lost without a write");

  AST_SER_MOD_SET: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    serial_req[SER_MOD] |-> ##1 ser_flag[SER_MOD] ##1 ser_flag[SER_MOD] || $past(we_ser)
  ) else $error("serial module flag not held");

  AST_ASYNC1_CLR: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (we_ser && !rb.wdata[FLAG_LSB + SER_ASYNC1] && !serial_req[SER_ASYNC1])
    |=> !ser_flag[SER_ASYNC1]
  ) else $error("async port1 flag not cleared by write");

  AST_ASYNC0_SETWIN: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (we_ser && serial_req[SER_ASYNC0]) |=> ser_flag[SER_ASYNC0]
  ) else $error("async port0 set lost against a clear");

  AST_SER_RSVD: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (rb.addr == OFF_SER) |-> !rb.rdata[SER_RSVD_HI] && !rb.rdata[SER_RSVD_LO]
  ) else $error("serial reserved bits read nonzero");

  AST_GRP_STICKY: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (grp_flag[0] && !we_mf) |=> grp_flag[0]
  ) else $error("group 0 flag dropped without software");

  AST_GIE_GATE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !gie_q |=> core_req_q == RST_EV
  ) else $error("request forwarded with global enable off");

  AST_RESET_ZERO: assert property (
    @(posedge ref_clk)
    !rst_n |=> flags == RST_EV && enables == RST_EV && !irq
  ) else $error("state not zero after reset");

  AST_IRQ_EVENT: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (|(ev & ev_mask_q) && !we_mask) |=> irq
  ) else $error("masked-in event did not raise irq");

  AST_GRP_FWD: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (grp_flag[0] && grp_en[0] && gie_q) |=> core_req_q[EV_GRP_LSB]
  ) else $error("group 0 request not forwarded");

  AST_GRP_READ: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (avs_read && !avs_waitrequest && avs_address == OFF_MF)
    |-> avs_readdata[REG_W-1:0] == {$past(grp_flag), $past(grp_en)}
  ) else $error("group control byte misread");

  AST_SOF_SET: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    usb_tick_req[UTB_SOF] |=> utb_flag[UTB_SOF]
  ) else $error("frame start flag not set by its request");

  AST_UTB_EN_WRITE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    we_utb |=> utb_en == $past(rb.wdata[EN_LSB +: UTB_N])
  ) else $error("usb and tick enables not loaded from write");

  AST_USB_SET: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    usb_tick_req[UTB_USB] |=> utb_flag[UTB_USB]
  ) else $error("usb flag not set by its request");

  AST_TICK0_SET: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    usb_tick_req[UTB_TICK0] |=> utb_flag[UTB_TICK0]
  ) else $error("tick0 flag not set by its request");

  AST_SER_READ: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (avs_read && !avs_waitrequest && avs_address == OFF_SER)
    |-> avs_readdata[FLAG_LSB + SER_MOD] == $past(ser_flag[SER_MOD])
      && avs_readdata[EN_LSB + SER_MOD] == $past(ser_en[SER_MOD])
  ) else $error("serial module bits misplaced");

  AST_SER_FWD: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ser_flag[SER_MOD] && ser_en[SER_MOD] && gie_q) |=> core_req_q[EV_SER_LSB + SER_MOD]
  ) else $error("serial module request not forwarded");

  AST_SER_EN_WRITE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    we_ser |=> ser_en == $past(rb.wdata[EN_LSB +: SER_N])
  ) else $error("serial enables not loaded from write");

  AST_ASYNC1_SET: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    serial_req[SER_ASYNC1] |=> ser_flag[SER_ASYNC1]
  ) else $error("async port1 flag not set by its request");

  AST_GIE_WRITE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    we_ctrl |=> gie_q == $past(rb.wdata[CTRL_GIE])
  ) else $error("global enable not loaded from write");

  AST_FWD_NEEDS_ALL: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    core_req_q[EV_GRP_LSB] |-> $past(grp_flag[0] && grp_en[0] && gie_q)
  ) else $error("group 0 forwarded without flag and enables");

  // A clear must remove every written bit when no event sets one in the same cycle
  AST_STAT_W1C: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (we_stat && ev == RST_EV) |=> (ev_stat_q & $past(wev)) == RST_EV
  ) else $error("event status bit not cleared by write of one");

  AST_WAIT_ONE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest
  ) else $error("bus access took more than one wait cycle");
endmodule // ifb_irq_bank

// File: design/ifb_pkg.sv
package ifb_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REG_W = 8;
  localparam int unsigned GRP_N = 4;
  localparam int unsigned UTB_N = 4;
  localparam int unsigned SER_N = 3;
  localparam int unsigned EV_W = 11;
  localparam int unsigned EV_GRP_LSB = 0;
  localparam int unsigned EV_UTB_LSB = 4;
  localparam int unsigned EV_SER_LSB = 8;
  // Byte offsets of the register words
  localparam logic [7:0] OFF_MF = 8'h00;
  localparam logic [7:0] OFF_UTB = 8'h04;
  localparam logic [7:0] OFF_SER = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_EV_STAT = 8'h10;
  localparam logic [7:0] OFF_EV_MASK = 8'h14;
  // Field positions inside the control bytes
  localparam int unsigned FLAG_LSB = 4;
  localparam int unsigned EN_LSB = 0;
  localparam int unsigned SER_RSVD_HI = 7;
  localparam int unsigned SER_RSVD_LO = 3;
  localparam int unsigned UTB_TICK0 = 0;
  localparam int unsigned UTB_TICK1 = 1;
  localparam int unsigned UTB_USB = 2;
  localparam int unsigned UTB_SOF = 3;
  localparam int unsigned SER_ASYNC0 = 0;
  localparam int unsigned SER_ASYNC1 = 1;
  localparam int unsigned SER_MOD = 2;
  localparam int unsigned CTRL_GIE = 0;
  localparam logic [7:0] RST_CTRL_BYTE = 8'h00;
  localparam logic [EV_W-1:0] RST_EV = 11'h000;
endpackage

// File: design/ifb_reg_if.sv
`timescale 1ns/10ps
interface ifb_reg_if;
  import ifb_pkg::*;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] rdata;
  modport bus (output wr, output addr, output wdata, output wmask, input rdata);
  modport regs (input wr, input addr, input wdata, input wmask, output rdata);
endinterface

// File: design/ifb_flag_bank.sv
`timescale 1ns/10ps
module ifb_flag_bank import ifb_pkg::*; #(
  parameter int unsigned N = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [N-1:0] hw_set,
  input wire logic sw_we,
  input wire logic [N-1:0] sw_flag,
  input wire logic [N-1:0] sw_en,
  output logic [N-1:0] flag_q,
  output logic [N-1:0] en_q
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      // Hardware set beats a software write of zero in the same cycle
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          flag_q[i] <= 1'b0;
        end else if (hw_set[i]) begin
          flag_q[i] <= 1'b1;
        end else if (sw_we) begin
          flag_q[i] <= sw_flag[i];
        end
      end
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          en_q[i] <= 1'b0;
        end else if (sw_we) begin
          en_q[i] <= sw_en[i];
        end
      end
    end
  endgenerate
endmodule // ifb_flag_bank

// File: design/ifb_avs.sv
`timescale 1ns/10ps
module ifb_avs import ifb_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  ifb_reg_if.bus rb
);
  logic ack_q;
  // One wait cycle per access keeps readdata registered
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rb.rdata;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign rb.wr = avs_write && ack_q;
  assign rb.addr = avs_address;
  assign rb.wdata = avs_writedata;
  assign rb.wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
endmodule // ifb_avs

// File: verification/ifb_src_model.sv
`timescale 1ns/10ps
module ifb_src_model import ifb_pkg::*; (
  input wire logic ref_clk,
  input wire logic fire,
  input wire logic [3:0] idx,
  output logic [GRP_N-1:0] group_src_req,
  output logic [UTB_N-1:0] usb_tick_req,
  output logic [SER_N-1:0] serial_req
);
  logic [EV_W-1:0] pulse_q;
  // One-cycle strobe per event, like a peripheral that fires once
  always_ff @(posedge ref_clk) begin
    pulse_q <= fire ? (EV_W'(1) << idx) : '0;
  end
  // Groups arrive already combined from their per-source registers
  assign group_src_req = pulse_q[EV_GRP_LSB+:GRP_N];
  assign usb_tick_req = pulse_q[EV_UTB_LSB+:UTB_N];
  assign serial_req = pulse_q[EV_SER_LSB+:SER_N];
endmodule // ifb_src_model

// File: verification/test_irq_flag_enable_bank.sv
`timescale 1ns/10ps
module test_irq_flag_enable_bank;
  import ifb_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [GRP_N-1:0] group_src_req;
  logic [UTB_N-1:0] usb_tick_req;
  logic [SER_N-1:0] serial_req;
  logic [EV_W-1:0] core_req_q;
  logic global_irq_en;
  logic irq;
  logic fire = 1'b0;
  logic [3:0] idx = '0;
  logic [DATA_W-1:0] rd;
  logic [7:0] rv;
  logic [7:0] mf_v;
  logic en;
  int n_errors = 0;
  int cmp_count = 0;
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  ifb_irq_bank u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .group_src_req(group_src_req),
    .usb_tick_req(usb_tick_req), .serial_req(serial_req), .core_req_q(core_req_q),
    .global_irq_en(global_irq_en), .irq(irq));
  ifb_src_model u_src (.ref_clk(ref_clk), .fire(fire), .idx(idx),
    .group_src_req(group_src_req), .usb_tick_req(usb_tick_req), .serial_req(serial_req));
  task automatic wrap_up();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t: value mismatch", $time);
    end
  endtask
  // Request stands until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Event pulse from the source model, then time for flag and forward stages
  task automatic pulse(input int i);
    @(posedge ref_clk);
    fire <= 1'b1;
    idx <= 4'(i);
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [7:0] reg_of(input int i);
    return OFF_MF + 8'(4 * (i / 4));
  endfunction
  initial begin
    void'($urandom(47880));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 28; a += 4) begin
      bus(1'b0, 8'(a), '0);
      chk(rd === 32'h0);
    end
    for (int r = 0; r < 3; r++) begin
      rv = 8'($urandom);
      if (r == 0) begin
        mf_v = rv;
      end
      bus(1'b1, 8'(4 * r), {24'h0, rv});
      bus(1'b0, 8'(4 * r), '0);
      chk(rd === {24'h0, (r == 2) ? (rv & 8'h77) : rv});
    end
    // A write with no byte lane must leave the register alone
    avs_byteenable <= 4'h0;
    bus(1'b1, OFF_MF, 32'hFF);
    avs_byteenable <= 4'hF;
    bus(1'b0, OFF_MF, '0);
    chk(rd === {24'h0, mf_v});
    bus(1'b1, OFF_MF, 32'h0);
    bus(1'b1, OFF_UTB, 32'h0);
    bus(1'b1, OFF_SER, 32'h0);
    bus(1'b1, OFF_CTRL, 32'h1);
    bus(1'b0, OFF_CTRL, '0);
    chk(rd === 32'h1);
    chk(global_irq_en === 1'b1);
    for (int i = 0; i < EV_W; i++) begin
      en = 1'($urandom_range(0, 1));
      bus(1'b1, reg_of(i), 32'(en) << (i % 4));
      bus(1'b1, OFF_EV_MASK, 32'(en) << i);
      pulse(i);
      chk(core_req_q === (EV_W'(en) << i));
      chk(irq === en);
      bus(1'b0, reg_of(i), '0);
      chk(rd === ((32'h10 << (i % 4)) | (32'(en) << (i % 4))));
      bus(1'b0, OFF_EV_STAT, '0);
      chk(rd === (32'h1 << i));
      bus(1'b1, reg_of(i), 32'(en) << (i % 4));
      bus(1'b1, OFF_EV_STAT, 32'h1 << i);
      #1;
      chk(irq === 1'b0);
      @(posedge ref_clk);
      #1;
      chk(core_req_q === '0);
    end
    bus(1'b1, OFF_CTRL, 32'h0);
    bus(1'b1, OFF_MF, 32'hF);
    pulse(0);
    chk(core_req_q === '0);
    chk(global_irq_en === 1'b0);
    // Event and software clear land in the same cycle: the event wins
    fork
      bus(1'b1, OFF_SER, 32'h0);
      begin
        @(posedge ref_clk);
        fire <= 1'b1;
        idx <= 4'(EV_SER_LSB + SER_ASYNC0);
        @(posedge ref_clk);
        fire <= 1'b0;
      end
    join
    bus(1'b0, OFF_SER, '0);
    chk(rd === 32'h10);
    // Reset in mid-run must wipe flags, enables and status
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b0, OFF_MF, '0);
    chk(rd === 32'h0);
    bus(1'b0, OFF_EV_STAT, '0);
    chk(rd === 32'h0);
    chk(irq === 1'b0);
    chk(core_req_q === '0);
    wrap_up();
  end
  initial begin
    #100000;
    n_errors++;
    $display("ERROR %0t: timeout", $time);
    wrap_up();
  end
endmodule // test_irq_flag_enable_bank
